// File: tb.sv
`timescale 1ns/1ps
module tb;
    // clock, reset and register port
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [10:0] regAddr;
    logic regWrite, regRead;
    logic [15:0] regWdata, regRdata;
    // block outputs
    logic regRdataValid, stageStart, convActive, irqLevelSelect, softRestart;
    logic driveOutputAEnable, driveOutputBEnable;
    logic [3:0] stageIndex;
    logic [1:0] decimationSelect, converterBiasBoost;
    // bookkeeping
    int checks = 0;
    int mismatches = 0;
    integer seed = 32'h8E2B;
    int nv[3] = '{0, 11, 15};
    logic [15:0] expQ[$];

    always #5 clk = ~clk;

    tcpc_host_model host_u (.clk, .regAddr, .regWrite, .regWdata, .regRead);
    // short stage and wake unit keep the run brief
    tcpc_power_control #(.STAGE_CYCLES(20), .IDLE_WAKE_UNIT_CYCLES(50))
        dut_u (.clk, .sys_rst, .regAddr, .regWrite, .regWdata, .regRead,
        .regRdata, .regRdataValid, .stageStart, .stageIndex, .convActive,
        .decimationSelect, .converterBiasBoost, .driveOutputAEnable,
        .driveOutputBEnable, .irqLevelSelect, .softRestart);

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rdExp(input logic [10:0] a, input logic [15:0] e);
        expQ.push_back(e);
        host_u.rd(a);
    endtask
    // cycles from one stage-zero start to the next, and starts seen
    task automatic measure(input logic [15:0] w, output int per,
                           output int cnt);
        int t;
        t = 0;
        per = 0;
        cnt = 0;
        host_u.wr(11'h000, w);
        while (!(stageStart === 1'b1 && stageIndex === 4'h0) && t < 2000) begin
            @(negedge clk);
            t++;
        end
        do begin
            @(negedge clk);
            per++;
            cnt += (stageStart === 1'b1);
        end while (!(stageStart === 1'b1 && stageIndex === 4'h0) &&
                   per < 2000);
        if (t >= 2000 || per >= 2000) begin
            mismatches++;
            print_verdict();
        end
        host_u.wr(11'h000, 16'h0001);
        repeat (10) @(negedge clk);
    endtask

    // each read answer against the oldest expectation
    always @(negedge clk) begin
        if (regRdataValid === 1'b1) begin
            if (expQ.size() == 0)
                check("read slot", 16'h0001, 16'h0000);
            else
                check("read data", expQ.pop_front(), regRdata);
        end
    end

    initial begin
        logic [15:0] w;
        int p0, p1, c;
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        rdExp(11'h000, 16'h0000);
        host_u.wr(11'h000, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            w = (16'($random(seed)) & 16'hF9FF) | 16'h0001;
            host_u.wr(11'h000, w);
            check("fields",
                {9'h000, w[11], ~w[13:12], w[15:14], w[9:8]},
                {9'h000, irqLevelSelect, driveOutputBEnable,
                driveOutputAEnable, converterBiasBoost, decimationSelect});
            rdExp(11'h000, w);
            check("idle", 16'h0000, {15'h0000, convActive});
        end
        // unmapped places do not store, and a read there answers zero
        host_u.wr(11'h001, 16'hFFFF);
        rdExp(11'h000, w);
        rdExp(11'h7F0, 16'h0000);
        host_u.wr(11'h000, 16'h0402);
        check("restart pulse", 16'h0001, {15'h0000, softRestart});
        rdExp(11'h000, 16'h0000);
        host_u.wr(11'h000, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            measure(16'(nv[k] << 4), p0, c);
            check("stages", 16'(nv[k] > 11 ? 12 : nv[k] + 1), 16'(c));
            check("period", 16'(20 * (nv[k] > 11 ? 12 : nv[k] + 1)),
                16'(p0));
        end
        measure(16'h0000, p0, c);
        measure(16'h0100, p1, c);
        check("decim gap", 16'h000A, 16'(p0 - p1));
        check("no sleep", 16'h0001, {15'h0000, p0 < 25});
        measure(16'h0002, p0, c);
        for (int d = 1; d < 4; d++) begin
            measure(16'h0002 | 16'(d << 2), p1, c);
            check("wake", 16'(50 * d), 16'(p1 - p0));
        end
        check("reads left", 16'h0000, 16'(expQ.size()));
        print_verdict();
    end
endmodule

// File: tcpc_host_model.sv
`timescale 1ns/1ps
module tcpc_host_model (
    // clock
    input wire logic clk,
    // register port toward the block
    output logic [10:0] regAddr,
    output logic regWrite,
    output logic [15:0] regWdata,
    output logic regRead
);
    // quiet port at time zero
    initial begin
        regAddr = 11'h7FF;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // one strobe cycle; inverted leftovers so stale data never looks valid
    task automatic access(input logic [10:0] a, input logic [15:0] d,
                          input logic isWrite);
        @(negedge clk);
        regAddr = a;
        regWdata = {d[15:10], 1'b0, d[8:0]};
        regWrite = isWrite;
        regRead = !isWrite;
        @(negedge clk);
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~regAddr;
        regWdata = ~regWdata;
    endtask
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        access(a, d, 1'b1);
    endtask
    task automatic rd(input logic [10:0] a);
        access(a, 16'h0000, 1'b0);
    endtask
endmodule

// File: tcpc_interval_timer.sv
`timescale 1ns/1ps
module tcpc_interval_timer (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic load,
    input wire logic [tcpc_pkg::TIMER_WIDTH-1:0] loadValue,
    // status
    output logic done
);

    // ------------------------------------------------------------
    // down counter
    // ------------------------------------------------------------
    localparam logic [tcpc_pkg::TIMER_WIDTH-1:0] CNT_ZERO = '0;
    localparam logic [tcpc_pkg::TIMER_WIDTH-1:0] CNT_ONE = 1;

    logic [tcpc_pkg::TIMER_WIDTH-1:0] count;
    logic [tcpc_pkg::TIMER_WIDTH-1:0] next_count;

    // a reload in the expiry cycle wins, so the old count never lingers
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadValue;
        end else if (count != CNT_ZERO) begin
            next_count = count - CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= CNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // done must not look at load: the sequencer raises load from done,
    // and gating done by load would close a combinational loop
    assign done = count == CNT_ONE;

endmodule

// File: tcpc_pkg.sv
package tcpc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [10:0] ADDR_POWER_AND_SEQUENCE_CONTROL = 11'h000;
    localparam logic [15:0] POWER_AND_SEQUENCE_CONTROL_RESET = 16'h0000;
    localparam int REG_WIDTH = 16;
    localparam int ADDR_WIDTH = 11;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int IDLE_WAKE_INTERVAL_LSB = 2;
    localparam int STAGE_COUNT_LSB = 4;
    localparam int DECIMATION_LSB = 8;
    localparam int SOFT_RESTART_TRIGGER_BIT = 10;
    localparam int IRQ_LEVEL_SELECT_BIT = 11;
    localparam int DRIVE_OUTPUT_A_DISABLE_BIT = 12;
    localparam int DRIVE_OUTPUT_B_DISABLE_BIT = 13;
    localparam int CONVERTER_BIAS_BOOST_LSB = 14;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_FULL_POWER = 2'h0;
    localparam logic [1:0] MODE_SHUTDOWN_A = 2'h1;
    localparam logic [1:0] MODE_LOW_POWER = 2'h2;
    localparam logic [1:0] MODE_SHUTDOWN_B = 2'h3;
    localparam logic [1:0] DECIM_256 = 2'h0;
    localparam logic [1:0] DECIM_128 = 2'h1;
    localparam logic [3:0] STAGE_COUNT_MAX = 4'hB;
    localparam logic [3:0] STAGE_ZERO = 4'h0;
    localparam logic [3:0] STAGE_STEP = 4'h1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int CYCLES_PER_US = CLK_MHZ;
    localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
    localparam int MAX_STAGES = 12;
    localparam int FULL_SEQUENCE_TIME_US = 36000;
    localparam int STAGE_TIME_US = FULL_SEQUENCE_TIME_US / MAX_STAGES;
    localparam int IDLE_WAKE_UNIT_MS = 200;
    localparam int TIMER_WIDTH = 32;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_CONVERT = 2'b01,
        ST_SLEEP = 2'b10
    } tcpc_state_t;

endpackage

// File: tcpc_power_control.sv
`timescale 1ns/1ps
module tcpc_power_control #(
    parameter int unsigned STAGE_CYCLES =
        tcpc_pkg::STAGE_TIME_US * tcpc_pkg::CYCLES_PER_US,
    parameter int unsigned IDLE_WAKE_UNIT_CYCLES =
        tcpc_pkg::IDLE_WAKE_UNIT_MS * tcpc_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port from the serial interface
    input wire logic [tcpc_pkg::ADDR_WIDTH-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [tcpc_pkg::REG_WIDTH-1:0] regWdata,
    input wire logic regRead,
    output logic [tcpc_pkg::REG_WIDTH-1:0] regRdata,
    output logic regRdataValid,
    // converter control
    output logic stageStart,
    output logic [3:0] stageIndex,
    output logic convActive,
    output logic [1:0] decimationSelect,
    output logic [1:0] converterBiasBoost,
    output logic driveOutputAEnable,
    output logic driveOutputBEnable,
    output logic irqLevelSelect,
    output logic softRestart
);

    // ------------------------------------------------------------
    // control word
    // ------------------------------------------------------------
    logic [tcpc_pkg::REG_WIDTH-1:0] ctrl;
    logic [tcpc_pkg::REG_WIDTH-1:0] next_ctrl;
    logic restartPulse;
    logic next_restartPulse;
    logic [tcpc_pkg::REG_WIDTH-1:0] next_regRdata;
    logic next_regRdataValid;
    logic hit;

    assign hit = regAddr == tcpc_pkg::ADDR_POWER_AND_SEQUENCE_CONTROL;

    // restart bit is never stored, so it reads zero
    always_comb begin
        next_ctrl = ctrl;
        next_restartPulse = 1'b0;
        next_regRdata = regRdata;
        next_regRdataValid = regRead;
        if (regWrite && hit) begin
            if (regWdata[tcpc_pkg::SOFT_RESTART_TRIGGER_BIT]) begin
                next_ctrl = tcpc_pkg::POWER_AND_SEQUENCE_CONTROL_RESET;
                next_restartPulse = 1'b1;
            end else begin
                next_ctrl = regWdata;
            end
            next_ctrl[tcpc_pkg::SOFT_RESTART_TRIGGER_BIT] = 1'b0;
        end
        if (regRead) begin
            next_regRdata = hit ? ctrl : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= tcpc_pkg::POWER_AND_SEQUENCE_CONTROL_RESET;
            restartPulse <= 1'b0;
            regRdata <= '0;
            regRdataValid <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            restartPulse <= next_restartPulse;
            regRdata <= next_regRdata;
            regRdataValid <= next_regRdataValid;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic [1:0] wakeCode;
    logic [3:0] lastStage;
    logic [1:0] decim;

    assign mode = ctrl[tcpc_pkg::MODE_LSB +: 2];
    assign wakeCode = ctrl[tcpc_pkg::IDLE_WAKE_INTERVAL_LSB +: 2];
    assign decim = ctrl[tcpc_pkg::DECIMATION_LSB +: 2];

    // oversized stage field is clamped rather than overrunning 12
    assign lastStage =
        (ctrl[tcpc_pkg::STAGE_COUNT_LSB +: 4] > tcpc_pkg::STAGE_COUNT_MAX) ?
        tcpc_pkg::STAGE_COUNT_MAX :
        ctrl[tcpc_pkg::STAGE_COUNT_LSB +: 4];

    // output fields are straight from the flops
    assign decimationSelect = decim;
    assign converterBiasBoost =
        ctrl[tcpc_pkg::CONVERTER_BIAS_BOOST_LSB +: 2];
    assign driveOutputAEnable =
        !ctrl[tcpc_pkg::DRIVE_OUTPUT_A_DISABLE_BIT];
    assign driveOutputBEnable =
        !ctrl[tcpc_pkg::DRIVE_OUTPUT_B_DISABLE_BIT];
    assign irqLevelSelect = ctrl[tcpc_pkg::IRQ_LEVEL_SELECT_BIT];
    assign softRestart = restartPulse;

    // stage length follows decimation; illegal codes fall back to 256
    function automatic logic [tcpc_pkg::TIMER_WIDTH-1:0] stageLen(
        input logic [1:0] d
    );
        logic [tcpc_pkg::TIMER_WIDTH-1:0] full;
        full = tcpc_pkg::TIMER_WIDTH'(STAGE_CYCLES);
        stageLen = (d == tcpc_pkg::DECIM_128) ? (full >> 1) : full;
    endfunction

    // wake delay is (code + 1) units of 200 ms
    function automatic logic [tcpc_pkg::TIMER_WIDTH-1:0] wakeLen(
        input logic [1:0] c
    );
        logic [tcpc_pkg::TIMER_WIDTH-1:0] mult;
        mult = tcpc_pkg::TIMER_WIDTH'(c) + 1;
        wakeLen = tcpc_pkg::TIMER_WIDTH'(
            mult * tcpc_pkg::TIMER_WIDTH'(IDLE_WAKE_UNIT_CYCLES));
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    tcpc_pkg::tcpc_state_t state;
    tcpc_pkg::tcpc_state_t next_state;
    logic [3:0] next_stageIndex;
    logic next_stageStart;
    logic timerLoad;
    logic [tcpc_pkg::TIMER_WIDTH-1:0] timerValue;
    logic timerDone;
    logic shutdown;

    assign shutdown = (mode == tcpc_pkg::MODE_SHUTDOWN_A) ||
                      (mode == tcpc_pkg::MODE_SHUTDOWN_B);

    // a mode change is taken at the next sequence end, except shutdown
    always_comb begin
        next_state = state;
        next_stageIndex = stageIndex;
        next_stageStart = 1'b0;
        timerLoad = 1'b0;
        timerValue = stageLen(decim);
        case (state)
            tcpc_pkg::ST_OFF: begin
                if (!shutdown) begin
                    next_state = tcpc_pkg::ST_CONVERT;
                    next_stageIndex = tcpc_pkg::STAGE_ZERO;
                    next_stageStart = 1'b1;
                    timerLoad = 1'b1;
                end
            end
            tcpc_pkg::ST_CONVERT: begin
                if (timerDone) begin
                    if (stageIndex < lastStage) begin
                        next_stageIndex = stageIndex + tcpc_pkg::STAGE_STEP;
                        next_stageStart = 1'b1;
                        timerLoad = 1'b1;
                    end else if (mode == tcpc_pkg::MODE_LOW_POWER) begin
                        next_state = tcpc_pkg::ST_SLEEP;
                        timerValue = wakeLen(wakeCode);
                        timerLoad = 1'b1;
                    end else begin
                        next_stageIndex = tcpc_pkg::STAGE_ZERO;
                        next_stageStart = 1'b1;
                        timerLoad = 1'b1;
                    end
                end
            end
            tcpc_pkg::ST_SLEEP: begin
                if (timerDone) begin
                    next_state = tcpc_pkg::ST_CONVERT;
                    next_stageIndex = tcpc_pkg::STAGE_ZERO;
                    next_stageStart = 1'b1;
                    timerLoad = 1'b1;
                end
            end
            default: begin
                next_state = tcpc_pkg::ST_OFF;
            end
        endcase
        if (shutdown || restartPulse) begin
            next_state = tcpc_pkg::ST_OFF;
            next_stageIndex = tcpc_pkg::STAGE_ZERO;
            next_stageStart = 1'b0;
            timerLoad = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= tcpc_pkg::ST_OFF;
            stageIndex <= tcpc_pkg::STAGE_ZERO;
            stageStart <= 1'b0;
        end else begin
            state <= next_state;
            stageIndex <= next_stageIndex;
            stageStart <= next_stageStart;
        end
    end

    assign convActive = state == tcpc_pkg::ST_CONVERT;

    // one shared timer serves both stage length and wake delay
    tcpc_interval_timer timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(timerLoad),
        .loadValue(timerValue),
        .done(timerDone)
    );

endmodule

// File: tcpc_power_control_props.sv
`timescale 1ns/1ps
module tcpc_power_control_chk (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [10:0] regAddr,
    input wire logic regWrite,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic regRdataValid,
    // converter control
    input wire logic stageStart,
    input wire logic [3:0] stageIndex,
    input wire logic convActive,
    input wire logic [1:0] decimationSelect,
    input wire logic [1:0] converterBiasBoost,
    input wire logic driveOutputAEnable,
    input wire logic driveOutputBEnable,
    input wire logic softRestart
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic plainWr;
    logic restartWr;
    logic [3:0] lastIdx;
    logic [3:0] next_lastIdx;
    // decoded writes to the control word
    assign plainWr = regWrite && regAddr == 11'h000 && !regWdata[10];
    assign restartWr = regWrite && regAddr == 11'h000 && regWdata[10];
    // last started stage, so a skipped index shows up
    always_comb begin
        next_lastIdx = stageStart ? stageIndex : lastIdx;
    end
    always_ff @(posedge clk) begin
        lastIdx <= sys_rst ? 4'h0 : next_lastIdx;
    end
    dec_follow_a: assert property (plainWr |=>
        decimationSelect == $past(regWdata[9:8])) else $error("decim lost");
    bias_follow_a: assert property (plainWr |=>
        converterBiasBoost == $past(regWdata[15:14])) else $error("bias lost");
    drive_level_a: assert property (plainWr |=>
        driveOutputAEnable == !$past(regWdata[12]) &&
        driveOutputBEnable == !$past(regWdata[13])) else $error("drive bad");
    restart_pulse_a: assert property (restartWr |=>
        softRestart ##1 !softRestart) else $error("restart pulse bad");
    restart_clear_a: assert property (restartWr |=>
        decimationSelect == 2'h0 && converterBiasBoost == 2'h0 &&
        driveOutputAEnable && driveOutputBEnable) else $error("not cleared");
    shutdown_quiet_a: assert property (plainWr && regWdata[0] |->
        ##2 (!convActive && !stageStart)[*4]) else $error("converts in off");
    stage_step_a: assert property (stageStart |->
        stageIndex <= 4'hB && (stageIndex == 4'h0 ||
        stageIndex == lastIdx + 4'h1)) else $error("stage order bad");
    restart_reads_a: assert property (regRdataValid |->
        !regRdata[10]) else $error("restart bit reads one");
    cover property (stageStart && stageIndex == 4'hB);
    cover property (softRestart);
    cover property (regRdataValid && regRdata != 16'h0000);
endmodule
bind tcpc_power_control tcpc_power_control_chk chk_u (.clk, .sys_rst,
    .regAddr, .regWrite, .regWdata, .regRdata, .regRdataValid, .stageStart,
    .stageIndex, .convActive, .decimationSelect, .converterBiasBoost,
    .driveOutputAEnable, .driveOutputBEnable, .softRestart);
